// >>> sim/ipd_queue_model.sv
// Instruction queue model feeding the decoder byte stream
module ipd_queue_model (
  input  wire logic       clk,
  input  wire logic       byte_ready,
  input  wire logic       slow,
  output logic            byte_valid,
  output logic [7:0]      byte_data,
  output logic            byte_is_opcode,
  output logic            opcode_indexed
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] q [$];
  logic       gap = 0;
  initial begin
    byte_valid = 0;
    byte_data = 8'h00;
    byte_is_opcode = 0;
    opcode_indexed = 0;
  end
  task automatic push(input logic op, input logic [7:0] b);
    q.push_back({op, b});
  endtask
  // Offer held until taken; idle data toggles so nothing stale lingers
  always @(posedge clk) begin
    if (!(byte_valid && !byte_ready)) begin
      if (byte_valid) void'(q.pop_front());
      gap <= slow && !gap;
      if (q.size() != 0 && !(slow && !gap)) begin
        byte_valid <= 1;
        {byte_is_opcode, byte_data} <= q[0];
        opcode_indexed <= q[0][8];
      end else begin
        byte_valid <= 0;
        byte_data <= ~byte_data;
      end
    end
  end
endmodule

// >>> sim/ipd_top_bench.sv
// Self-checking bench for the postbyte decoder
module ipd_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, sys_rst = 1, slow = 0, reg_wr = 0, reg_rd = 0;
  logic byte_valid, byte_is_opcode, opcode_indexed, byte_ready, dec_valid;
  logic dec_page2, dec_auto_post, dec_indirect, dec_illegal;
  logic dec_pointer_fetch;
  logic [7:0] byte_data, dec_opcode, reg_rdata, reg_wdata = 0;
  logic [1:0] dec_base, dec_acc_choice;
  logic [2:0] dec_kind;
  logic [15:0] dec_offset;
  logic [3:0] reg_addr = 0;
  logic [31:0] rs = 32'h7a91_2d85, r;
  int fail_count = 0, n_tests = 0, cyc = 0;
  logic [7:0] pbs [14] = '{8'h0f, 8'h10, 8'he0, 8'he9, 8'hf2, 8'hfb,
    8'he4, 8'hfd, 8'hee, 8'hff, 8'h27, 8'h78, 8'hbf, 8'h30};
  always #2 clk = ~clk;
  ipd_top u_ipd_top (.*);
  ipd_queue_model u_ipd_queue_model (.*);
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task automatic reg_read(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    @(negedge clk);
    chk("reg_rdata", e, reg_rdata);
  endtask
  task automatic run(input logic pg, blk, input logic [7:0] op, pb,
                     input logic [15:0] ex);
    int n, i;
    logic [1:0] b;
    logic [2:0] k;
    logic [15:0] o;
    n = 0;
    o = ex;
    b = &pb[7:5] ? pb[4:3] : pb[7:6];
    k = &pb[1:0] ? 3'h6 : 3'h5;
    if (!pb[5]) {k, o} = {3'h0, {11{pb[4]}}, pb[4:0]};
    else if (!(&pb[7:5])) begin
      k = 3'h4;
      o = pb[3] ? {12'hfff, pb[3:0]} : {12'h000, pb[3:0]} + 16'h1;
    end else if (!pb[2]) begin
      n = pb[1] ? 2 : 1;
      k = pb[1] ? {2'b01, pb[0]} : 3'h1;
      if (!pb[1]) o = {{8{pb[0]}}, ex[7:0]};
    end
    if (pg) u_ipd_queue_model.push(1, 8'h18);
    u_ipd_queue_model.push(1, op);
    u_ipd_queue_model.push(0, pb);
    if (n == 2) u_ipd_queue_model.push(0, ex[15:8]);
    if (n != 0) u_ipd_queue_model.push(0, ex[7:0]);
    if (blk) begin
      @(negedge clk);
      chk("ready", 0, byte_ready);
      repeat (8) @(negedge clk) chk("held", 0, dec_valid);
      reg_write(4'h0, 8'h01);
    end
    for (i = 0; i < 40 && dec_valid !== 1; i++) @(negedge clk);
    chk("page2", pg, dec_page2);
    chk("opcode", op, dec_opcode);
    chk("form", {2'b10, b, k, k == 3'h3 || k == 3'h6}, {dec_valid,
      dec_illegal, dec_base, dec_kind, dec_indirect});
    chk("fetch", k == 3'h3 || k == 3'h6, dec_pointer_fetch);
    if (k < 3'h5) chk("offset", o, dec_offset);
    if (k == 3'h4) chk("post", pb[4], dec_auto_post);
    if (k == 3'h5) chk("acc", pb[1:0], dec_acc_choice);
    @(negedge clk);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    reg_read(4'h0, 8'h01);
    reg_read(4'hf, 8'h00);
    foreach (pbs[i]) run(i[0], 0, 8'ha6, pbs[i], 16'h80ff);
    reg_write(4'h0, 8'h00);
    run(0, 1, 8'h6a, 8'he2, 16'h1234);
    reg_write(4'h0, 8'h03);
    reg_write(4'h0, 8'h01);
    repeat (150) begin
      r = rnd();
      slow <= r[0];
      run(r[1], 0, r[23:16] ^ 8'(r[23:16] == 8'h18), r[15:8], r[31:16]);
    end
    reg_read(4'h5, 8'h96);
    tally_and_finish();
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
endmodule

// >>> sim/ipd_top_checker.sv
// Port-level properties of the postbyte decoder
module ipd_top_checker (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        byte_valid,
  input wire logic        byte_ready,
  input wire logic        dec_valid,
  input wire logic [1:0]  dec_base,
  input wire logic [2:0]  dec_kind,
  input wire logic [15:0] dec_offset,
  input wire logic [1:0]  dec_acc_choice,
  input wire logic        dec_indirect,
  input wire logic        dec_pointer_fetch
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  valid_pulse_a: assert property (dec_valid |=> !dec_valid)
    else $error("dec_valid held");
  answer_slot_a: assert property (
    dec_valid |-> $past(byte_valid && byte_ready)) else $error("late");
  indirect_kind_a: assert property (dec_valid |->
    dec_indirect == (dec_kind == 3'h3 || dec_kind == 3'h6))
    else $error("indirect flag");
  fetch_indirect_a: assert property (
    dec_pointer_fetch |-> dec_indirect) else $error("fetch");
  short_range_a: assert property (dec_valid && dec_kind == 3'h0 |->
    dec_offset[15:4] == 12'h000 || dec_offset[15:4] == 12'hfff)
    else $error("5-bit range");
  nine_range_a: assert property (dec_valid && dec_kind == 3'h1 |->
    dec_offset[15:8] == 8'h00 || dec_offset[15:8] == 8'hff)
    else $error("9-bit range");
  auto_amount_a: assert property (dec_valid && dec_kind == 3'h4 |->
    dec_offset inside {[16'h0001:16'h0008], [16'hfff8:16'hffff]})
    else $error("update amount");
  auto_base_a: assert property (dec_valid && dec_kind == 3'h4 |->
    dec_base != 2'h3) else $error("auto on pc");
  acc_select_a: assert property (dec_valid && dec_kind == 3'h5 |->
    dec_acc_choice != 2'h3) else $error("acc choice");
endmodule

bind ipd_top ipd_top_checker u_ipd_top_checker (.*);

// >>> src/ipd_dec_if.sv
// Decoded postbyte carrier between decoder and sequencer
interface ipd_dec_if;
  import ipd_pkg::*;
  logic [7:0] indexed_postbyte;
  ipd_dec_t   dec;
  modport decoder (input indexed_postbyte, output dec);
  modport user    (output indexed_postbyte, input dec);
endinterface

// >>> src/ipd_defines.svh
// Constants for the indexed postbyte decoder
`ifndef IPD_DEFINES_SVH
`define IPD_DEFINES_SVH
`define IPD_PAGE2_PREFIX   8'h18
`define IPD_OFFSET_COUNT   (3'h0)
`define IPD_REG_CTRL       4'h0
`define IPD_REG_OPCODE     4'h1
`define IPD_REG_POSTBYTE   4'h2
`define IPD_REG_STATUS     4'h3
`define IPD_REG_OFFSET     4'h4
`define IPD_REG_COUNT      4'h5
`define IPD_CTRL_RESET     8'h01
`define IPD_CTRL_EN_BIT    0
`define IPD_CTRL_CLR_BIT   1
`define IPD_ACC_A          2'h0
`define IPD_ACC_B          2'h1
`define IPD_ACC_D          2'h2
`define IPD_ACC_DIND       2'h3
`endif

// >>> src/ipd_pkg.sv
// Types for the indexed postbyte decoder
package ipd_pkg;
  typedef enum logic [1:0] {
    IPD_BASE_X  = 2'h0,
    IPD_BASE_Y  = 2'h1,
    IPD_BASE_SP = 2'h2,
    IPD_BASE_PC = 2'h3
  } ipd_base_t;

  typedef enum logic [2:0] {
    IPD_OFS_CONST5 = 3'h0,
    IPD_OFS_CONST9 = 3'h1,
    IPD_OFS_CONST16 = 3'h2,
    IPD_OFS_IND16 = 3'h3,
    IPD_OFS_AUTO = 3'h4,
    IPD_OFS_ACC = 3'h5,
    IPD_OFS_IND_D = 3'h6
  } ipd_kind_t;

  typedef enum logic [1:0] {
    IPD_ST_OPCODE = 2'b00,
    IPD_ST_POST   = 2'b01,
    IPD_ST_EXT    = 2'b11
  } ipd_state_t;

  typedef struct packed {
    logic          valid;
    ipd_base_t     base;
    ipd_kind_t     kind;
    logic [1:0]    ext_count;
    logic [15:0]   const_offset;
    logic [1:0]    acc_choice;
    logic          auto_post;
    logic          indirect;
    logic          illegal;
  } ipd_dec_t;
endpackage

// >>> src/ipd_postbyte_dec.sv
// Combinational decode of one indexed postbyte
module ipd_postbyte_dec
  import ipd_pkg::*;
(
  ipd_dec_if.decoder dif
);
`include "ipd_defines.svh"

  logic [7:0] pb;
  assign pb = dif.indexed_postbyte;

  always_comb begin
    ipd_dec_t d;
    d = '0;
    d.valid = 1'b1;
    if (!pb[5]) begin
      d.base = ipd_base_t'(pb[7:6]);
      d.kind = IPD_OFS_CONST5;
      d.const_offset = {{11{pb[4]}}, pb[4:0]};
      d.ext_count = 2'd0;
    end else if (pb[7:5] != 3'b111) begin
      d.base = ipd_base_t'(pb[7:6]);
      d.kind = IPD_OFS_AUTO;
      d.auto_post = pb[4];
      // +1..+8 stored as 0..7, negatives as two's complement
      d.const_offset = pb[3] ? {{12{1'b1}}, pb[3:0]}
                             : {12'h000, pb[3:0]} + 16'h0001;
      d.illegal = 1'b0;
      d.ext_count = 2'd0;
    end else begin
      d.base = ipd_base_t'(pb[4:3]);
      if (!pb[2]) begin
        if (pb[1:0] == 2'b11) begin
          d.kind = IPD_OFS_IND16;
          d.indirect = 1'b1;
          d.ext_count = 2'd2;
        end else if (pb[1]) begin
          d.kind = IPD_OFS_CONST16;
          d.ext_count = 2'd2;
        end else begin
          d.kind = IPD_OFS_CONST9;
          d.const_offset = {{8{pb[0]}}, 8'h00};
          d.ext_count = 2'd1;
        end
      end else begin
        d.acc_choice = pb[1:0];
        if (pb[1:0] == `IPD_ACC_DIND) begin
          d.kind = IPD_OFS_IND_D;
          d.indirect = 1'b1;
        end else begin
          d.kind = IPD_OFS_ACC;
        end
        d.ext_count = 2'd0;
      end
    end
    dif.dec = d;
  end
endmodule

// >>> src/ipd_top.sv
// Indexed postbyte decoder with opcode page tracking and register port
//
// Notes on behaviour
// - Base select 00=X, 01=Y, 10=SP, 11=PC.
// - rr0nnnnn gives 5-bit signed offset -16..+15, no extension bytes.
// - Constant offsets 5, 9 and 16 bits; wide forms via 111rr0zs.
// - One postbyte after opcode, then zero, one or two extension bytes.
// - 111rr011 is 16-bit offset indexed-indirect from any base.
// - rr1pnnnn auto update; p=0 pre, p=1 post; PC invalid.
// - Update +1..+8 coded 0000..0111; negatives two's complement.
// - 111rr1aa accumulator offset: A, B, D; 11 is D indirect.
// - 111rr111 indirect through base plus D, any base.
// - Opcodes 8-bit; byte 18 hex prefixes second page.
// - Postbyte may encode transfer/exchange/loop; extensions are data.
// - 9-bit form low byte in one extension; 16-bit uses two.
// - Indirect forms first read 16-bit pointer, then use it.
module ipd_top
  import ipd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_data,
  input  wire logic        byte_is_opcode,
  input  wire logic        opcode_indexed,
  output logic             byte_ready,
  output logic             dec_valid,
  output logic             dec_page2,
  output logic [7:0]       dec_opcode,
  output logic [1:0]       dec_base,
  output logic [2:0]       dec_kind,
  output logic [15:0]      dec_offset,
  output logic [1:0]       dec_acc_choice,
  output logic             dec_auto_post,
  output logic             dec_indirect,
  output logic             dec_illegal,
  output logic             dec_pointer_fetch,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata
);
`include "ipd_defines.svh"

  typedef struct packed {
    ipd_state_t  st;
    logic        page2;
    logic        opc_page2;
    logic [7:0]  opcode;
    logic [7:0]  postbyte;
    ipd_dec_t    dec;
    logic [1:0]  ext_left;
    logic [15:0] offset;
    logic        out_valid;
    logic        ptr_fetch;
    logic [7:0]  ctrl;
    logic        err;
    logic [7:0]  done_count;
    logic [7:0]  rdata;
  } ipd_state_rec_t;

  ipd_state_rec_t r;
  ipd_state_rec_t next_r;

  ipd_dec_if dif();
  assign dif.indexed_postbyte = byte_data;

  ipd_postbyte_dec u_dec (
    .dif (dif.decoder)
  );

  function automatic logic [7:0] read_mux(input ipd_state_rec_t s,
                                          input logic [3:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `IPD_REG_CTRL:     v = s.ctrl;
      `IPD_REG_OPCODE:   v = s.opcode;
      `IPD_REG_POSTBYTE: v = s.postbyte;
      `IPD_REG_STATUS:   v = {4'h0, s.err, s.page2, s.st};
      `IPD_REG_OFFSET:   v = s.offset[7:0];
      `IPD_REG_COUNT:    v = s.done_count;
      default:           v = 8'h00;
    endcase
    return v;
  endfunction

  logic enabled;
  assign enabled = r.ctrl[`IPD_CTRL_EN_BIT];
  assign byte_ready = enabled;

  always_comb begin
    next_r = r;
    next_r.out_valid = 1'b0;
    next_r.ptr_fetch = 1'b0;
    next_r.rdata = reg_rd ? read_mux(r, reg_addr) : 8'h00;
    if (enabled && byte_valid) begin
      unique case (r.st)
        IPD_ST_OPCODE: begin
          if (byte_is_opcode && byte_data == `IPD_PAGE2_PREFIX && !r.page2)
          begin
            next_r.page2 = 1'b1;
          end else begin
            next_r.opcode = byte_data;
            // Page of this opcode is kept beside it; prefix is consumed
            next_r.opc_page2 = r.page2;
            next_r.page2 = 1'b0;
            // Non-indexed postbytes (transfer, loop) pass undecoded
            next_r.st = opcode_indexed ? IPD_ST_POST : IPD_ST_OPCODE;
          end
        end
        IPD_ST_POST: begin
          next_r.postbyte = byte_data;
          next_r.dec = dif.dec;
          next_r.offset = dif.dec.const_offset;
          next_r.ext_left = dif.dec.ext_count;
          if (dif.dec.kind == IPD_OFS_AUTO && byte_data[7:6] == 2'b11) begin
            next_r.err = 1'b1;
            next_r.dec.illegal = 1'b1;
          end
          if (dif.dec.ext_count == 2'd0) begin
            next_r.st = IPD_ST_OPCODE;
            next_r.out_valid = 1'b1;
            next_r.ptr_fetch = dif.dec.indirect;
            next_r.done_count = r.done_count + 8'h01;
          end else begin
            next_r.st = IPD_ST_EXT;
          end
        end
        IPD_ST_EXT: begin
          if (r.dec.kind == IPD_OFS_CONST9) begin
            next_r.offset = {r.offset[15:8], byte_data};
          end else if (r.ext_left == 2'd2) begin
            next_r.offset = {byte_data, 8'h00};
          end else begin
            next_r.offset = {r.offset[15:8], byte_data};
          end
          next_r.ext_left = r.ext_left - 2'd1;
          if (r.ext_left == 2'd1) begin
            next_r.st = IPD_ST_OPCODE;
            next_r.out_valid = 1'b1;
            next_r.ptr_fetch = r.dec.indirect;
            next_r.done_count = r.done_count + 8'h01;
          end
        end
        default: next_r.st = IPD_ST_OPCODE;
      endcase
    end
    if (reg_wr && reg_addr == `IPD_REG_CTRL) begin
      next_r.ctrl = reg_wdata;
      if (reg_wdata[`IPD_CTRL_CLR_BIT]) begin
        next_r.err = 1'b0;
        next_r.done_count = 8'h00;
      end
    end
    if (enabled && byte_valid && r.st == IPD_ST_POST &&
        dif.dec.kind == IPD_OFS_AUTO && byte_data[7:6] == 2'b11) begin
      next_r.err = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
      r.ctrl <= `IPD_CTRL_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign dec_valid         = r.out_valid;
  assign dec_page2         = r.opc_page2;
  assign dec_opcode        = r.opcode;
  assign dec_base          = r.dec.base;
  assign dec_kind          = r.dec.kind;
  assign dec_offset        = r.offset;
  assign dec_acc_choice    = r.dec.acc_choice;
  assign dec_auto_post     = r.dec.auto_post;
  assign dec_indirect      = r.dec.indirect;
  assign dec_illegal       = r.dec.illegal;
  assign dec_pointer_fetch = r.ptr_fetch;
  assign reg_rdata         = r.rdata;
endmodule
